// ### rtl/slhi_consts.svh
// Offsets, field positions, reset values and timing constants (clock MHz, delay microseconds) of the link host interface
// ==========================================================================
`ifndef SLHI_CONSTS_SVH
`define SLHI_CONSTS_SVH

// ==========================================================================
// Register byte addresses
`define SLHI_ADDR_VECTOR   8'h00
`define SLHI_ADDR_DATA     8'h04
`define SLHI_ADDR_DELAY    8'h08
`define SLHI_ADDR_PORTCTL  8'h0C
`define SLHI_ADDR_PINDATA  8'h10
`define SLHI_ADDR_PORTDIR  8'h14
`define SLHI_ADDR_CTL2     8'h18

// ==========================================================================
// Field positions
`define SLHI_VEC_LSB       2
`define SLHI_DLY_XCVR_SEL  7
`define SLHI_DLY_RX_POL    6
`define SLHI_PCTL_ENABLE   2
`define SLHI_PCTL_PULLUP   1
`define SLHI_PCTL_REDUCED  0
`define SLHI_CTL2_EOD      0
`define SLHI_CTL2_DIGITAL_LOOPBACK    1
`define SLHI_CTL2_ANALOG_LOOPBACK    2
`define SLHI_PIN_RX        0
`define SLHI_PIN_TX        1

// ==========================================================================
// Reset values
`define SLHI_RST_DELAY     8'h00
`define SLHI_RST_PORTCTL   8'h00
`define SLHI_RST_PINDATA   8'h00
`define SLHI_RST_PORTDIR   8'h00
`define SLHI_RST_CTL2      8'h00

// ==========================================================================
// Timing
`define SLHI_CLK_MHZ       20
`define SLHI_DLY_BASE_US   9
`define SLHI_DLY_STEP_US   1

`endif

// ### rtl/slhi_pkg.sv
// Types shared by the link host interface
package slhi_pkg;

  // Events from the frame engine, one-cycle pulses
  typedef struct packed {
    logic       eof;
    logic       resp_byte;
    logic       rx_byte;
    logic [7:0] rx_data;
    logic       tx_byte_done;
    logic       tx_first_bit;
    logic       eod_sent;
    logic       arb_lost;
    logic       crc_err;
    logic       bad_symbol;
    logic       wakeup;
  } slhi_evt_t;

  // Commands to the frame engine
  typedef struct packed {
    logic       load;
    logic [7:0] data;
    logic       send_eod;
    logic       underrun;
    logic       active;
  } slhi_cmd_t;

  typedef enum logic [8:0] {
    SLHI_SRC_NONE  = 9'b000000001,
    SLHI_SRC_EOF   = 9'b000000010,
    SLHI_SRC_RESP  = 9'b000000100,
    SLHI_SRC_RXF   = 9'b000001000,
    SLHI_SRC_TXE   = 9'b000010000,
    SLHI_SRC_ARB   = 9'b000100000,
    SLHI_SRC_CRC   = 9'b001000000,
    SLHI_SRC_SYM   = 9'b010000000,
    SLHI_SRC_WAKE  = 9'b100000000
  } slhi_src_t;

endpackage

// ### rtl/slhi_host_regs.sv
// APB register bank, state vector and port logic of the link host interface
`timescale 1ns/1ps
`include "slhi_consts.svh"

module slhi_host_regs #(
  parameter int PINS = 7
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              special_mode,
  input  wire slhi_pkg::slhi_evt_t evt,
  output slhi_pkg::slhi_cmd_t    cmd,
  output logic                   link_rx_level,
  input  wire logic              link_tx_level,
  output logic                   xcvr_select,
  output logic [9:0]             comp_delay_cycles,
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe,
  output logic                   pin_pullup_en,
  output logic                   pin_reduced_drive
);

  // ==========================================================================
  // Parameter check
  if (PINS < 2 || PINS > 8) begin : g_bad_pins
    $error("PINS must lie between 2 and 8");
  end
  // Ten bits of delay count must cover the whole offset range at this clock
  if ((`SLHI_DLY_BASE_US + 15 * `SLHI_DLY_STEP_US) * `SLHI_CLK_MHZ > 1023) begin : g_bad_delay
    $error("Delay compensation does not fit ten bits");
  end

  // ==========================================================================
  // Functions
  function automatic logic [3:0] src_code(input logic [8:1] p);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 1; i <= 8; i++) begin
      if (p[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] w);
    return w[7:0];
  endfunction

  function automatic logic waits_data_rd(input logic [3:0] c);
    return (c == 4'h2) || (c == 4'h3);
  endfunction

  function automatic logic waits_data_wr(input logic [3:0] c);
    return c == 4'h4;
  endfunction

  function automatic logic clears_on_read(input logic [3:0] c);
    return (c != 4'h0) && !waits_data_rd(c) && !waits_data_wr(c);
  endfunction

  // ==========================================================================
  // Registers
  logic [8:1]     pend_q;
  logic [8:1]     pend_d;
  logic [7:0]     tx_shadow_q;
  logic           tx_full_q;
  logic [7:0]     rx_shadow_q;
  logic           rx_armed_q;
  logic           tx_armed_q;
  logic [7:0]     delay_q;
  logic           delay_wr_q;
  logic [7:0]     pctl_q;
  logic [PINS-1:0] pdata_q;
  logic [PINS-1:0] pdir_q;
  logic [2:0]     ctl2_q;
  logic           wait_eof_q;
  logic [31:0]    prdata_q;
  slhi_pkg::slhi_cmd_t cmd_q;

  // ==========================================================================
  // Bus decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire rd      = access & ~pwrite;
  wire hit_vec = (paddr == `SLHI_ADDR_VECTOR);
  wire hit_dat = (paddr == `SLHI_ADDR_DATA);
  wire hit_dly = (paddr == `SLHI_ADDR_DELAY);
  wire hit_pct = (paddr == `SLHI_ADDR_PORTCTL);
  wire hit_pdt = (paddr == `SLHI_ADDR_PINDATA);
  wire hit_pdr = (paddr == `SLHI_ADDR_PORTDIR);
  wire hit_ct2 = (paddr == `SLHI_ADDR_CTL2);
  wire mapped  = hit_vec | hit_dat | hit_dly | hit_pct | hit_pdt | hit_pdr | hit_ct2;
  wire [7:0] wbyte = byte_of(pwdata);

  // ==========================================================================
  // Link gating
  wire enabled   = pctl_q[`SLHI_PCTL_ENABLE];
  wire looped    = ctl2_q[`SLHI_CTL2_DIGITAL_LOOPBACK] | ctl2_q[`SLHI_CTL2_ANALOG_LOOPBACK];
  wire bus_on    = enabled & ~looped;
  wire link_ok   = bus_on & ~wait_eof_q;
  wire [3:0] code = src_code(pend_q);
  wire [3:0] rd_code = prdata_q[`SLHI_VEC_LSB +: 4];

  // Vector value captured at setup, so side effects use the code software saw
  wire vec_rd   = rd & hit_vec;
  wire vec_clr  = vec_rd && clears_on_read(rd_code);
  wire dat_rd   = rd & hit_dat;
  wire dat_wr   = wr & hit_dat;
  wire eod_set  = wr & hit_ct2 & wbyte[`SLHI_CTL2_EOD];

  // ==========================================================================
  // Transmit path events
  wire byte_done = link_ok & evt.tx_byte_done;
  wire do_load   = byte_done & tx_full_q;
  wire do_eod    = byte_done & ~tx_full_q & ctl2_q[`SLHI_CTL2_EOD];
  wire do_under  = byte_done & ~tx_full_q & ~ctl2_q[`SLHI_CTL2_EOD];

  // ==========================================================================
  // Qualified events; end-of-frame, symbol and wakeup still count while waiting for end-of-frame
  wire set_eof   = bus_on & evt.eof;
  wire set_resp  = link_ok & evt.resp_byte;
  wire set_rxf   = link_ok & evt.rx_byte;
  wire set_txe   = link_ok & evt.tx_first_bit;
  wire set_arb   = link_ok & evt.arb_lost;
  wire set_crc   = link_ok & evt.crc_err;
  wire set_sym   = (bus_on & evt.bad_symbol) | do_under;
  wire set_wake  = bus_on & evt.wakeup;
  wire clr_rx    = dat_rd & rx_armed_q;
  wire clr_tx    = (dat_wr & tx_armed_q) | eod_set;

  // ==========================================================================
  // Register write strobes
  wire dly_we    = wr & hit_dly & (special_mode | ~delay_wr_q);
  wire pct_we    = wr & hit_pct;
  wire pdt_we    = wr & hit_pdt;
  wire pdr_we    = wr & hit_pdr;
  wire ct2_we    = wr & hit_ct2;
  wire eod_clr   = do_eod | ~enabled;

  // ==========================================================================
  // Pending sources; each set wins over a clear in the same cycle
  always_comb begin
    pend_d = pend_q;
    if (vec_clr) begin
      pend_d[rd_code] = 1'b0;
    end
    if (clr_rx) begin
      pend_d[2] = 1'b0;
      pend_d[3] = 1'b0;
    end
    if (clr_tx) begin
      pend_d[4] = 1'b0;
    end
    if (!enabled) begin
      pend_d = '0;
    end else begin
      if (set_eof) begin
        pend_d[1] = 1'b1;
      end
      if (set_resp) begin
        pend_d[2] = 1'b1;
      end
      if (set_rxf) begin
        pend_d[3] = 1'b1;
      end
      if (set_txe) begin
        pend_d[4] = 1'b1;
      end
      if (set_arb) begin
        pend_d[5] = 1'b1;
      end
      if (set_crc) begin
        pend_d[6] = 1'b1;
      end
      if (set_sym) begin
        pend_d[7] = 1'b1;
      end
      if (set_wake) begin
        pend_d[8] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State vector and data buffer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q      <= '0;
      rx_armed_q  <= 1'b0;
      tx_armed_q  <= 1'b0;
      wait_eof_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      if (vec_rd) begin
        rx_armed_q <= waits_data_rd(rd_code);
        tx_armed_q <= waits_data_wr(rd_code);
      end else begin
        if (dat_rd) begin
          rx_armed_q <= 1'b0;
        end
        if (dat_wr) begin
          tx_armed_q <= 1'b0;
        end
      end
      // Blocking after a symbol clear keeps a corrupt frame from being half-taken
      if (vec_clr && rd_code == 4'h7) begin
        wait_eof_q <= 1'b1;
      end else if (set_eof) begin
        wait_eof_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shadow_q <= 8'h00;
      tx_full_q   <= 1'b0;
      rx_shadow_q <= 8'h00;
    end else begin
      if (dat_wr) begin
        tx_shadow_q <= wbyte;
      end
      if (dat_wr) begin
        tx_full_q <= 1'b1;
      end else if (do_load || !enabled) begin
        tx_full_q <= 1'b0;
      end
      // Unread data is lost here; software has one byte time
      if (link_ok && (evt.rx_byte || evt.resp_byte)) begin
        rx_shadow_q <= evt.rx_data;
      end
    end
  end

  // ==========================================================================
  // Frame engine commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_q <= '0;
    end else begin
      cmd_q.load     <= do_load;
      cmd_q.send_eod <= do_eod;
      cmd_q.underrun <= do_under;
      cmd_q.active   <= link_ok;
      if (do_load) begin
        cmd_q.data <= tx_shadow_q;
      end
    end
  end
  assign cmd = cmd_q;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_q    <= `SLHI_RST_DELAY;
      delay_wr_q <= 1'b0;
      pctl_q     <= `SLHI_RST_PORTCTL;
      pdata_q    <= PINS'(`SLHI_RST_PINDATA);
      pdir_q     <= PINS'(`SLHI_RST_PORTDIR);
      ctl2_q     <= 3'(`SLHI_RST_CTL2);
    end else begin
      if (dly_we) begin
        delay_q    <= wbyte & 8'hCF;
        delay_wr_q <= 1'b1;
      end
      if (pct_we) begin
        pctl_q <= wbyte & 8'h07;
      end
      if (pdt_we) begin
        pdata_q <= wbyte[PINS-1:0];
      end
      if (pdr_we) begin
        pdir_q <= wbyte[PINS-1:0];
      end
      if (ct2_we) begin
        ctl2_q <= wbyte[2:0];
      end else if (eod_clr) begin
        ctl2_q[`SLHI_CTL2_EOD] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pins
  logic [PINS-1:0] link_mask;
  logic [PINS-1:0] link_drive;
  logic [PINS-1:0] pin_read;
  always_comb begin
    link_mask  = '0;
    link_drive = '0;
    if (bus_on) begin
      link_mask[`SLHI_PIN_RX]  = 1'b1;
      link_mask[`SLHI_PIN_TX]  = 1'b1;
      link_drive[`SLHI_PIN_TX] = link_tx_level;
    end
  end
  // Link-driven pins ignore the data latch at pin_out; pin_read still returns it where the direction bit is set
  assign pin_oe   = (pdir_q & ~link_mask) | (link_mask & ~(PINS'(1) << `SLHI_PIN_RX));
  assign pin_out  = (pdata_q & ~link_mask) | link_drive;
  assign pin_read = (pdir_q & pdata_q) | (~pdir_q & pin_in);
  assign pin_pullup_en     = pctl_q[`SLHI_PCTL_PULLUP];
  assign pin_reduced_drive = pctl_q[`SLHI_PCTL_REDUCED];

  // Polarity zero means the transceiver inverted the bus
  assign link_rx_level = pin_in[`SLHI_PIN_RX] ^ ~delay_q[`SLHI_DLY_RX_POL];
  assign xcvr_select   = delay_q[`SLHI_DLY_XCVR_SEL];

  localparam logic [9:0] DLY_BASE = 10'(`SLHI_DLY_BASE_US * `SLHI_CLK_MHZ);
  localparam logic [9:0] DLY_STEP = 10'(`SLHI_DLY_STEP_US * `SLHI_CLK_MHZ);
  assign comp_delay_cycles = DLY_BASE + 10'(delay_q[3:0]) * DLY_STEP;

  // ==========================================================================
  // Register read words
  wire [31:0] vec_word = {24'h0, 2'b00, code, 2'b00};
  wire [31:0] dat_word = {24'h0, rx_shadow_q};
  wire [31:0] dly_word = {24'h0, delay_q};
  wire [31:0] pct_word = {24'h0, pctl_q};
  wire [31:0] pdt_word = 32'(pin_read);
  wire [31:0] pdr_word = 32'(pdir_q);
  wire [31:0] ct2_word = {29'h0, ctl2_q};

  // ==========================================================================
  // Read data, captured in the setup cycle
  logic [31:0] rmux;
  always_comb begin
    if (hit_vec) begin
      rmux = vec_word;
    end else if (hit_dat) begin
      rmux = dat_word;
    end else if (hit_dly) begin
      rmux = dly_word;
    end else if (hit_pct) begin
      rmux = pct_word;
    end else if (hit_pdt) begin
      rmux = pdt_word;
    end else if (hit_pdr) begin
      rmux = pdr_word;
    end else if (hit_ct2) begin
      rmux = ct2_word;
    end else begin
      rmux = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= rmux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

endmodule

// ### sim/slhi_engine_model.sv
// Frame engine stand-in: shifts loaded bytes and reports byte timing
`timescale 1ns/1ps
module slhi_engine_model #(
  parameter int BYTE_CYC = 32
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                kick,
  input  wire slhi_pkg::slhi_evt_t inj,
  input  wire slhi_pkg::slhi_cmd_t cmd,
  output slhi_pkg::slhi_evt_t      evt,
  output logic                     tx_level
);
  logic [7:0] sh_q;
  int         cnt_q;
  logic       first_q;
  logic       done_q;
  // ==========================================================================
  // Byte shifter, idles recessive so the pin never shows stale data
  always_ff @(posedge clk) begin
    first_q <= 1'b0;
    done_q  <= 1'b0;
    if (sys_rst) begin
      cnt_q <= 0;
      sh_q  <= 8'hFF;
    end else if (cmd.load) begin
      sh_q  <= cmd.data;
      cnt_q <= BYTE_CYC;
    end else if (kick) begin
      done_q <= 1'b1;
    end else if (cnt_q > 0) begin
      cnt_q   <= cnt_q - 1;
      first_q <= (cnt_q == BYTE_CYC - 4);
      done_q  <= (cnt_q == 1);
      if (cnt_q % 4 == 1) sh_q <= {sh_q[6:0], 1'b1};
    end
  end
  always_comb begin
    evt              = inj;
    evt.tx_first_bit = inj.tx_first_bit | first_q;
    evt.tx_byte_done = inj.tx_byte_done | done_q;
  end
  assign tx_level = sh_q[7];
endmodule

// ### sim/slhi_host_checker.sv
// Port assertions for the link host interface
`timescale 1ns/1ps
`include "slhi_consts.svh"
module slhi_host_checker #(
  parameter int PINS = 7
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic [PINS-1:0]     pin_oe,
  input wire logic [9:0]          comp_delay_cycles,
  input wire slhi_pkg::slhi_evt_t evt,
  input wire slhi_pkg::slhi_cmd_t cmd
);
  logic            en_q;
  logic [PINS-1:0] dir_q;
  wire             wr_hit = psel && penable && pwrite;
  // ==========================================================================
  // Shadow of enable and direction, tracked from bus writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q  <= 1'b0;
      dir_q <= '0;
    end else begin
      if (wr_hit && paddr == `SLHI_ADDR_PORTCTL) en_q <= pwdata[`SLHI_PCTL_ENABLE];
      if (wr_hit && paddr == `SLHI_ADDR_PORTDIR) dir_q <= pwdata[PINS-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Assertions
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> pin_oe == '0 && cmd == '0)
    else $error("outputs not quiet after reset");
  chk_gpio_oe: assert property (!en_q |-> pin_oe == dir_q)
    else $error("pin enables differ from direction while link off");
  chk_upper_dir: assert property (pin_oe[PINS-1:2] == dir_q[PINS-1:2])
    else $error("general pin enable differs from direction");
  chk_delay_range: assert property (comp_delay_cycles % 20 == 0 && comp_delay_cycles inside {[180:480]})
    else $error("delay compensation outside table");
  chk_vec_format: assert property (psel && penable && !pwrite && paddr == `SLHI_ADDR_VECTOR
    |-> prdata[31:6] == '0 && prdata[1:0] == 2'b00 && prdata[5:2] <= 4'h8)
    else $error("vector read malformed");
  chk_load_cause: assert property ($rose(cmd.load) |-> $past(evt.tx_byte_done))
    else $error("byte load without finished byte");
  chk_underrun_cause: assert property (cmd.underrun |-> $past(evt.tx_byte_done) && !cmd.load)
    else $error("underrun without byte end");
  chk_eod_cause: assert property (cmd.send_eod |-> $past(evt.tx_byte_done) && !cmd.underrun)
    else $error("end of data outside byte end");
  cover property (cmd.underrun);
  cover property (cmd.send_eod);
  cover property (psel && penable && paddr == `SLHI_ADDR_VECTOR && prdata[5:2] == 4'h8);
endmodule
bind slhi_host_regs slhi_host_checker #(.PINS(PINS)) u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pin_oe(pin_oe),
  .comp_delay_cycles(comp_delay_cycles), .evt(evt), .cmd(cmd));

// ### sim/slhi_host_regs_tb.sv
// Self-checking bench for the link host interface register bank
`timescale 1ns/1ps
`include "slhi_consts.svh"
module slhi_host_regs_tb;
  localparam logic [7:0] VEC = `SLHI_ADDR_VECTOR;
  localparam logic [7:0] DAT = `SLHI_ADDR_DATA;
  localparam logic [7:0] DLY = `SLHI_ADDR_DELAY;
  localparam logic [7:0] CTL = `SLHI_ADDR_PORTCTL;
  localparam logic [7:0] PIN = `SLHI_ADDR_PINDATA;
  localparam logic [7:0] DIR = `SLHI_ADDR_PORTDIR;
  localparam logic [7:0] CT2 = `SLHI_ADDR_CTL2;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                last_err;
  logic                special_mode = 1'b0;
  logic                kick = 1'b0;
  logic                tx_level;
  logic                rx_level;
  logic                xsel;
  logic [9:0]          comp_delay_cycles;
  logic [6:0]          pin_in = 7'h00;
  logic [6:0]          pin_out;
  logic [6:0]          pin_oe;
  logic                pull_en;
  logic                low_drive;
  slhi_pkg::slhi_evt_t evt;
  slhi_pkg::slhi_evt_t inj = '0;
  slhi_pkg::slhi_cmd_t cmd;
  int                  bad_count = 0;
  int                  num_checks = 0;
  slhi_host_regs #(.PINS(7)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .evt(evt), .cmd(cmd), .link_rx_level(rx_level), .link_tx_level(tx_level),
    .xcvr_select(xsel), .comp_delay_cycles(comp_delay_cycles), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pull_en), .pin_reduced_drive(low_drive));
  slhi_engine_model u_eng (.clk(clk), .sys_rst(sys_rst), .kick(kick), .inj(inj), .cmd(cmd), .evt(evt),
    .tx_level(tx_level));
  always #25 clk = ~clk;
  // ==========================================================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail_out();
    bad_count++;
    final_report();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    last_err = pslverr;
    if (n >= 16) fail_out();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic pulse(input slhi_pkg::slhi_evt_t e);
    inj <= e;
    @(posedge clk);
    inj <= '0;
    @(posedge clk);
  endtask
  // Waits on load, first bit, end of data or underrun; each wait is bounded
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(k == 0 ? cmd.load : k == 1 ? evt.tx_first_bit : k == 2 ? cmd.send_eod : cmd.underrun) && n < 200);
    if (n >= 200) fail_out();
    @(posedge clk);
  endtask
  task automatic go();
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(VEC, 32'h0);
    rd(DLY, 32'h0);
    rd(CTL, 32'h0);
    rd(DIR, 32'h0);
    check(32'(pin_oe), 32'h0);
  endtask
  task automatic t_delay();
    pin_in <= 7'h01;
    wr(DLY, 32'h4F); // select bit kept zero
    rd(DLY, 32'h4F);
    check(32'(comp_delay_cycles), 32'd480);
    check(32'(rx_level), 32'h1);
    check(32'(xsel), 32'h0);
    wr(DLY, 32'h00);
    rd(DLY, 32'h4F);
    special_mode <= 1'b1;
    wr(DLY, 32'h03);
    rd(DLY, 32'h03);
    check(32'(comp_delay_cycles), 32'd240);
    check(32'(rx_level), 32'h0);
    special_mode <= 1'b0;
  endtask
  task automatic t_port();
    wr(CTL, 32'h03);
    check(32'({pull_en, low_drive}), 32'h3);
    wr(DIR, 32'h7F);
    wr(PIN, 32'h2A);
    rd(PIN, 32'h2A);
    check(32'(pin_out), 32'h2A);
    check(32'(pin_oe), 32'h7F);
    wr(DIR, 32'h0F);
    pin_in <= 7'h55;
    rd(PIN, 32'h5A);
    wr(CTL, 32'h04);
    wr(PIN, 32'h00);
    check(32'(pin_oe[1]), 32'h1);
    check(32'(pin_out[1]), 32'(tx_level));
  endtask
  task automatic t_prio();
    pulse('{eof: 1'b1, default: '0});
    pulse('{crc_err: 1'b1, default: '0});
    pulse('{arb_lost: 1'b1, default: '0});
    pulse('{wakeup: 1'b1, default: '0});
    rd(VEC, 32'h20);
    rd(VEC, 32'h18);
    rd(VEC, 32'h14);
    rd(VEC, 32'h04);
    rd(VEC, 32'h00);
  endtask
  task automatic t_rx();
    pulse('{rx_byte: 1'b1, rx_data: 8'hA5, default: '0});
    pulse('{rx_byte: 1'b1, rx_data: 8'h3C, default: '0});
    rd(VEC, 32'h0C);
    rd(VEC, 32'h0C);
    rd(DAT, 32'h3C);
    rd(VEC, 32'h00);
    pulse('{resp_byte: 1'b1, rx_data: 8'h77, default: '0});
    rd(DAT, 32'h77);
    rd(VEC, 32'h08);
    rd(DAT, 32'h77);
    rd(VEC, 32'h00);
  endtask
  task automatic t_loop();
    wr(CT2, 32'h02);
    @(posedge clk);
    check(32'(cmd.active), 32'h0);
    pulse('{wakeup: 1'b1, default: '0});
    rd(VEC, 32'h00);
    wr(CT2, 32'h04);
    pulse('{crc_err: 1'b1, default: '0});
    rd(VEC, 32'h00);
    wr(CT2, 32'h00);
  endtask
  task automatic t_tx();
    wr(DAT, 32'h55);
    go();
    wait_for(0);
    check(32'(cmd.data), 32'h55);
    rd(VEC, 32'h00);
    wait_for(1);
    rd(VEC, 32'h10);
    wr(DAT, 32'hA6); // only after empty shown
    rd(VEC, 32'h00);
    wait_for(0);
    check(32'(cmd.data), 32'hA6);
    wait_for(1);
    rd(VEC, 32'h10);
    wr(CT2, 32'h01);
    rd(VEC, 32'h00);
    wait_for(2);
    wr(DAT, 32'h5A);
    go();
    wait_for(0);
    wait_for(1);
    rd(VEC, 32'h10);
    wait_for(3);
    rd(VEC, 32'h1C);
    rd(VEC, 32'h10);
    wr(CTL, 32'h00);
    wr(CTL, 32'h04);
  endtask
  task automatic t_symbol();
    pulse('{bad_symbol: 1'b1, default: '0});
    rd(VEC, 32'h1C);
    pulse('{rx_byte: 1'b1, rx_data: 8'h22, default: '0});
    rd(VEC, 32'h00);
    check(32'(cmd.active), 32'h0);
    pulse('{eof: 1'b1, default: '0});
    @(posedge clk);
    check(32'(cmd.active), 32'h1);
    rd(VEC, 32'h04);
    pulse('{rx_byte: 1'b1, rx_data: 8'h22, default: '0});
    rd(VEC, 32'h0C);
    rd(DAT, 32'h22);
    rd(VEC, 32'h00);
    rd(8'h1C, 32'h0);
    check(32'(last_err), 32'h1);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_delay();
    t_port();
    t_prio();
    t_rx();
    t_loop();
    t_tx();
    t_symbol();
    final_report();
  end
endmodule
